// File: include/imc_defines.vh
`ifndef IMC_DEFINES_VH
`define IMC_DEFINES_VH

// register byte offsets
`define IMC_OFS_CTRL_ONE 8'h00
`define IMC_OFS_SEQ_CTRL 8'h04
`define IMC_OFS_BAUD_ADDR 8'h08
`define IMC_OFS_BUFFER 8'h0C
`define IMC_OFS_STATUS 8'h10
`define IMC_OFS_AUX 8'h14

// serial_port_control_one fields
`define IMC_CTL_COLLISION 7
`define IMC_CTL_OVERFLOW 6
`define IMC_CTL_ENABLE 5
`define IMC_CTL_CLK_RELEASE 4
`define IMC_CTL_MODE_HI 3
`define IMC_CTL_MODE_LO 0

// bus_sequence_control fields
`define IMC_SEQ_GCALL 7
`define IMC_SEQ_ACK_STATUS_BIT 6
`define IMC_SEQ_ACK_DATA_BIT 5
`define IMC_SEQ_ACK_SEQUENCE_ENABLE 4
`define IMC_SEQ_MASTER_RECEIVE_ENABLE 3
`define IMC_SEQ_PEN 2
`define IMC_SEQ_REPEATED_START_ENABLE 1
`define IMC_SEQ_SEN 0

// status fields
`define IMC_STS_BUF_FULL 0
`define IMC_STS_EVENT 1

// aux fields
`define IMC_AUX_FW_SDA 0
`define IMC_AUX_FW_SCL 1
`define IMC_AUX_ADDR_HI_LO 2
`define IMC_AUX_ADDR_HI_HI 3

// reset values
`define IMC_RST_CTRL_ONE 8'h00
`define IMC_RST_SEQ_CTRL 8'h00
`define IMC_RST_BAUD_ADDR 8'h00
`define IMC_RST_AUX 8'h03

// port mode codes
`define IMC_MODE_SLV7 4'h6
`define IMC_MODE_SLV10 4'h7
`define IMC_MODE_MASTER 4'h8
`define IMC_MODE_FW_MASTER 4'hB
`define IMC_MODE_SLV7_SP 4'hE
`define IMC_MODE_SLV10_SP 4'hF

// bus engine operations
`define IMC_OP_START 3'h0
`define IMC_OP_RSTART 3'h1
`define IMC_OP_STOP 3'h2
`define IMC_OP_ACK 3'h3
`define IMC_OP_RECV 3'h4
`define IMC_OP_XMIT 3'h5

// timing: quarters per serial clock period
`define IMC_QUARTERS_PER_BIT 4

`endif

// File: rtl/imc_bus_engine.v
`timescale 1ns/10ps
`include "imc_defines.vh"

module imc_bus_engine #(
    parameter DIV_W = 8
) (
    input wire clk_in,
    input wire rst_in,
    input wire ce_in,
    input wire [DIV_W-1:0] divisor_in,
    input wire scl_in,
    input wire sda_in,
    input wire go_in,
    input wire [2:0] op_in,
    input wire [7:0] tx_byte_in,
    input wire ack_bit_in,
    output reg busy_out,
    output reg done_out,
    output reg [7:0] rx_byte_out,
    output reg ack_status_out,
    output reg scl_oe_out,
    output reg sda_oe_out
);
    localparam ST_IDLE = 7'b0000001;
    localparam ST_START = 7'b0000010;
    localparam ST_RSTART = 7'b0000100;
    localparam ST_STOP = 7'b0001000;
    localparam ST_ACK = 7'b0010000;
    localparam ST_RECV = 7'b0100000;
    localparam ST_XMIT = 7'b1000000;

    reg [6:0] state_q;
    reg [DIV_W-1:0] div_q;
    reg [1:0] quarter_q;
    reg [3:0] bit_q;
    reg [8:0] shift_q;
    reg samp_q;
    reg hold_scl_q;
    reg hold_sda_q;
    reg scl_lvl;
    reg sda_lvl;
    reg [3:0] nbits;
    reg [6:0] target;
    wire tick = (div_q == divisor_in);
    // stretch is judged at the end of the high phase: the six-cycle pin round trip fits
    // inside two quarters only for divisors of 3 and up, so the period stays 4*(divisor+1)
    wire stretched = tick && (quarter_q == 2'd2) && scl_lvl && !scl_in;

    always @* begin
        case (op_in)
            `IMC_OP_START: target = ST_START;
            `IMC_OP_RSTART: target = ST_RSTART;
            `IMC_OP_STOP: target = ST_STOP;
            `IMC_OP_ACK: target = ST_ACK;
            `IMC_OP_RECV: target = ST_RECV;
            `IMC_OP_XMIT: target = ST_XMIT;
            default: target = ST_IDLE;
        endcase
    end

    // line levels per quarter; one serial period is four quarters of divisor+1 cycles
    always @* begin
        nbits = 4'd1;
        scl_lvl = hold_scl_q;
        sda_lvl = hold_sda_q;
        case (state_q)
            ST_IDLE: begin
            end
            ST_START: begin
                sda_lvl = (quarter_q == 2'd0);
                scl_lvl = (quarter_q < 2'd2);
            end
            ST_RSTART: begin
                sda_lvl = (quarter_q < 2'd2);
                scl_lvl = (quarter_q == 2'd1) || (quarter_q == 2'd2);
            end
            ST_STOP: begin
                sda_lvl = (quarter_q >= 2'd2);
                scl_lvl = (quarter_q >= 2'd1);
            end
            ST_ACK, ST_RECV, ST_XMIT: begin
                nbits = (state_q == ST_XMIT) ? 4'd9 : ((state_q == ST_RECV) ? 4'd8 : 4'd1);
                scl_lvl = (quarter_q == 2'd1) || (quarter_q == 2'd2);
                sda_lvl = (state_q == ST_RECV) ? 1'b1 : shift_q[8];
            end
            default: begin
            end
        endcase
    end

    always @(posedge clk_in) begin
        if (rst_in) begin
            state_q <= ST_IDLE;
            div_q <= {DIV_W{1'b0}};
            quarter_q <= 2'd0;
            bit_q <= 4'd0;
            shift_q <= 9'h1_FF;
            samp_q <= 1'b1;
            hold_scl_q <= 1'b1;
            hold_sda_q <= 1'b1;
            busy_out <= 1'b0;
            done_out <= 1'b0;
            rx_byte_out <= 8'h00;
            ack_status_out <= 1'b0;
            scl_oe_out <= 1'b0;
            sda_oe_out <= 1'b0;
        end else if (ce_in) begin
            done_out <= 1'b0;
            scl_oe_out <= ~scl_lvl;
            sda_oe_out <= ~sda_lvl;
            if (state_q == ST_IDLE) begin
                if (go_in) begin
                    state_q <= target;
                    busy_out <= 1'b1;
                    div_q <= {DIV_W{1'b0}};
                    quarter_q <= 2'd0;
                    bit_q <= 4'd0;
                    if (op_in == `IMC_OP_XMIT)
                        shift_q <= {tx_byte_in, 1'b1};
                    else if (op_in == `IMC_OP_ACK)
                        shift_q <= {ack_bit_in, 8'hFF};
                    else
                        shift_q <= 9'h1_FF;
                end
            end else if (stretched) begin
                // a slave holding scl low pauses the quarter count
                div_q <= {DIV_W{1'b0}};
            end else if (!tick) begin
                div_q <= div_q + {{(DIV_W-1){1'b0}}, 1'b1};
            end else begin
                div_q <= {DIV_W{1'b0}};
                quarter_q <= quarter_q + 2'd1;
                if (quarter_q == 2'd2)
                    samp_q <= sda_in;
                if (quarter_q == 2'd3) begin
                    shift_q <= {shift_q[7:0], samp_q};
                    bit_q <= bit_q + 4'd1;
                    if (bit_q + 4'd1 == nbits) begin
                        state_q <= ST_IDLE;
                        busy_out <= 1'b0;
                        done_out <= 1'b1;
                        hold_scl_q <= (state_q == ST_STOP);
                        hold_sda_q <= !((state_q == ST_START) || (state_q == ST_RSTART));
                        if (state_q == ST_XMIT)
                            ack_status_out <= samp_q;
                        if (state_q == ST_RECV)
                            rx_byte_out <= {shift_q[6:0], samp_q};
                    end
                end
            end
        end
    end
endmodule // imc_bus_engine

// File: rtl/imc_top.v
// Added by the designer: register access over APB and the address map.
`timescale 1ns/10ps
`include "imc_defines.vh"

// What this block does
// - a four-bit port mode field picks the function and the reserved codes select none.
// - code 0110 makes a 7-bit address slave with no start or stop events.
// - code 0111 makes a 10-bit address slave with no start or stop events.
// - codes 1110 and 1111 are the 7-bit and 10-bit slaves that also flag start and stop.
// - code 1000 is bus master with serial clock at oscillator over four times baud plus one.
// - code 1011 is a master where firmware drives the lines directly and the slave idles.
// - the master never sets overflow; a transmit starts from a buffer write, a receive from the receive enable bit.
module imc_top (
    input wire CLK_SYS_IN,
    input wire SYS_RST_IN,
    input wire CE_IN,
    input wire APB_PSEL_IN,
    input wire APB_PENABLE_IN,
    input wire APB_PWRITE_IN,
    input wire [7:0] APB_PADDR_IN,
    input wire [31:0] APB_PWDATA_IN,
    output reg [31:0] APB_PRDATA_OUT,
    output reg APB_PREADY_OUT,
    output reg APB_PSLVERR_OUT,
    input wire SCL_IN,
    input wire SDA_IN,
    output reg SCL_OUT,
    output reg SCL_OE_OUT,
    output reg SDA_OUT,
    output reg SDA_OE_OUT,
    output reg PORT_EVENT_OUT
);
    localparam SP_IDLE = 5'b00001;
    localparam SP_ADDR1 = 5'b00010;
    localparam SP_ADDR2 = 5'b00100;
    localparam SP_DATA = 5'b01000;
    localparam SP_SKIP = 5'b10000;

    reg [7:0] ctl_q;
    reg [7:0] seq_q;
    reg [7:0] baud_q;
    reg [7:0] buf_q;
    reg [7:0] aux_q;
    reg bf_q;
    reg event_q;
    reg tx_pend_q;
    reg inflight_q;
    reg go_q;
    reg [2:0] op_q;
    reg [2:0] scl_s_q;
    reg [2:0] sda_s_q;
    reg scl_f_q;
    reg sda_f_q;
    reg scl_p_q;
    reg sda_p_q;
    reg [4:0] sp_q;
    reg [3:0] sbit_q;
    reg [7:0] sshift_q;
    reg sack_q;
    reg [31:0] rdata;
    reg hit;

    wire eng_busy;
    wire eng_done;
    wire [7:0] eng_rx;
    wire eng_ack;
    wire eng_scl_oe;
    wire eng_sda_oe;

    wire [3:0] mode = ctl_q[`IMC_CTL_MODE_HI:`IMC_CTL_MODE_LO];
    wire en = ctl_q[`IMC_CTL_ENABLE];
    // reserved codes fall through all three decodes and leave the lines released
    wire is_master = en && (mode == `IMC_MODE_MASTER);
    wire is_fw = en && (mode == `IMC_MODE_FW_MASTER);
    wire is_ten = (mode == `IMC_MODE_SLV10) || (mode == `IMC_MODE_SLV10_SP);
    wire is_slave = en && ((mode == `IMC_MODE_SLV7) || (mode == `IMC_MODE_SLV7_SP) || is_ten);
    wire sp_events = (mode == `IMC_MODE_SLV7_SP) || (mode == `IMC_MODE_SLV10_SP);

    wire acc = APB_PSEL_IN && APB_PENABLE_IN && APB_PREADY_OUT;
    wire wr = acc && APB_PWRITE_IN;
    wire rd = acc && !APB_PWRITE_IN;
    wire [7:0] wd = APB_PWDATA_IN[7:0];

    wire scl_rise = scl_f_q && !scl_p_q;
    wire scl_fall = !scl_f_q && scl_p_q;
    wire bus_start = !sda_f_q && sda_p_q && scl_f_q && scl_p_q;
    wire bus_stop = sda_f_q && !sda_p_q && scl_f_q && scl_p_q;
    wire seq_busy = inflight_q || go_q || tx_pend_q || (seq_q[4:0] != 5'h00);
    wire [1:0] addr_hi = aux_q[`IMC_AUX_ADDR_HI_HI:`IMC_AUX_ADDR_HI_LO];

    imc_bus_engine #(
        .DIV_W(8)
    ) u_engine (
        .clk_in(CLK_SYS_IN),
        .rst_in(SYS_RST_IN || !is_master),
        .ce_in(CE_IN),
        .divisor_in(baud_q),
        .scl_in(scl_f_q),
        .sda_in(sda_f_q),
        .go_in(go_q),
        .op_in(op_q),
        .tx_byte_in(buf_q),
        .ack_bit_in(seq_q[`IMC_SEQ_ACK_DATA_BIT]),
        .busy_out(eng_busy),
        .done_out(eng_done),
        .rx_byte_out(eng_rx),
        .ack_status_out(eng_ack),
        .scl_oe_out(eng_scl_oe),
        .sda_oe_out(eng_sda_oe)
    );

    always @* begin
        hit = 1'b1;
        rdata = 32'h0000_0000;
        case (APB_PADDR_IN)
            `IMC_OFS_CTRL_ONE: rdata[7:0] = ctl_q;
            `IMC_OFS_SEQ_CTRL: rdata[7:0] = seq_q;
            `IMC_OFS_BAUD_ADDR: rdata[7:0] = baud_q;
            `IMC_OFS_BUFFER: rdata[7:0] = buf_q;
            `IMC_OFS_STATUS: rdata[1:0] = {event_q, bf_q};
            `IMC_OFS_AUX: rdata[7:0] = {2'b00, scl_f_q, sda_f_q, aux_q[3:0]};
            default: hit = 1'b0;
        endcase
    end

    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            APB_PRDATA_OUT <= 32'h0000_0000;
            APB_PREADY_OUT <= 1'b0;
            APB_PSLVERR_OUT <= 1'b0;
            SCL_OUT <= 1'b0;
            SDA_OUT <= 1'b0;
            SCL_OE_OUT <= 1'b0;
            SDA_OE_OUT <= 1'b0;
            PORT_EVENT_OUT <= 1'b0;
            ctl_q <= `IMC_RST_CTRL_ONE;
            seq_q <= `IMC_RST_SEQ_CTRL;
            baud_q <= `IMC_RST_BAUD_ADDR;
            aux_q <= `IMC_RST_AUX;
            buf_q <= 8'h00;
            bf_q <= 1'b0;
            event_q <= 1'b0;
            tx_pend_q <= 1'b0;
            inflight_q <= 1'b0;
            go_q <= 1'b0;
            op_q <= `IMC_OP_START;
            scl_s_q <= 3'b111;
            sda_s_q <= 3'b111;
            scl_f_q <= 1'b1;
            sda_f_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            sp_q <= SP_IDLE;
            sbit_q <= 4'd0;
            sshift_q <= 8'h00;
            sack_q <= 1'b0;
        end else if (CE_IN) begin
            // pins: three stages, level taken once the last two agree
            scl_s_q <= {scl_s_q[1:0], SCL_IN};
            sda_s_q <= {sda_s_q[1:0], SDA_IN};
            if (scl_s_q[1] == scl_s_q[2])
                scl_f_q <= scl_s_q[2];
            if (sda_s_q[1] == sda_s_q[2])
                sda_f_q <= sda_s_q[2];
            scl_p_q <= scl_f_q;
            sda_p_q <= sda_f_q;

            // apb: one wait state, answer registered
            APB_PREADY_OUT <= APB_PSEL_IN && APB_PENABLE_IN && !APB_PREADY_OUT;
            APB_PSLVERR_OUT <= APB_PSEL_IN && APB_PENABLE_IN && !APB_PREADY_OUT && !hit;
            APB_PRDATA_OUT <= rdata;

            // software writes; hardware updates further down win on the same bit
            if (wr) begin
                case (APB_PADDR_IN)
                    `IMC_OFS_CTRL_ONE: begin
                        ctl_q[5:0] <= wd[5:0];
                        ctl_q[7] <= ctl_q[7] & wd[7];
                        ctl_q[6] <= ctl_q[6] & wd[6];
                    end
                    `IMC_OFS_SEQ_CTRL: begin
                        seq_q[`IMC_SEQ_GCALL] <= wd[`IMC_SEQ_GCALL];
                        seq_q[`IMC_SEQ_ACK_DATA_BIT] <= wd[`IMC_SEQ_ACK_DATA_BIT];
                        // sequence bits are ignored unless the master is idle
                        if (is_master && !seq_busy)
                            seq_q[4:0] <= wd[4:0];
                    end
                    `IMC_OFS_BAUD_ADDR: baud_q <= wd;
                    `IMC_OFS_BUFFER: begin
                        if (is_master && seq_busy) begin
                            ctl_q[`IMC_CTL_COLLISION] <= 1'b1;
                        end else begin
                            buf_q <= wd;
                            tx_pend_q <= is_master;
                            bf_q <= is_master;
                        end
                    end
                    `IMC_OFS_STATUS: if (wd[`IMC_STS_EVENT]) event_q <= 1'b0;
                    `IMC_OFS_AUX: aux_q[3:0] <= wd[3:0];
                    default: begin
                    end
                endcase
            end
            if (rd && (APB_PADDR_IN == `IMC_OFS_BUFFER) && !is_master)
                bf_q <= 1'b0;

            // master: launch one operation at a time, sequence bits first
            go_q <= 1'b0;
            if (!is_master) begin
                seq_q[4:0] <= 5'h00;
                tx_pend_q <= 1'b0;
                inflight_q <= 1'b0;
            end else if (!inflight_q && !go_q && !eng_busy) begin
                go_q <= seq_q[4:0] != 5'h00 || tx_pend_q;
                inflight_q <= seq_q[4:0] != 5'h00 || tx_pend_q;
                if (seq_q[`IMC_SEQ_SEN])
                    op_q <= `IMC_OP_START;
                else if (seq_q[`IMC_SEQ_REPEATED_START_ENABLE])
                    op_q <= `IMC_OP_RSTART;
                else if (seq_q[`IMC_SEQ_PEN])
                    op_q <= `IMC_OP_STOP;
                else if (seq_q[`IMC_SEQ_ACK_SEQUENCE_ENABLE])
                    op_q <= `IMC_OP_ACK;
                else if (seq_q[`IMC_SEQ_MASTER_RECEIVE_ENABLE])
                    op_q <= `IMC_OP_RECV;
                else
                    op_q <= `IMC_OP_XMIT;
            end
            if (is_master && eng_done) begin
                inflight_q <= 1'b0;
                event_q <= 1'b1;
                case (op_q)
                    `IMC_OP_START: seq_q[`IMC_SEQ_SEN] <= 1'b0;
                    `IMC_OP_RSTART: seq_q[`IMC_SEQ_REPEATED_START_ENABLE] <= 1'b0;
                    `IMC_OP_STOP: seq_q[`IMC_SEQ_PEN] <= 1'b0;
                    `IMC_OP_ACK: seq_q[`IMC_SEQ_ACK_SEQUENCE_ENABLE] <= 1'b0;
                    `IMC_OP_RECV: begin
                        seq_q[`IMC_SEQ_MASTER_RECEIVE_ENABLE] <= 1'b0;
                        buf_q <= eng_rx;
                        bf_q <= 1'b1;
                    end
                    default: begin
                        tx_pend_q <= 1'b0;
                        bf_q <= 1'b0;
                        seq_q[`IMC_SEQ_ACK_STATUS_BIT] <= eng_ack;
                    end
                endcase
            end

            // slave: receive-only address matcher
            if (!is_slave || bus_stop) begin
                sp_q <= SP_IDLE;
                sack_q <= 1'b0;
            end else if (bus_start) begin
                sp_q <= SP_ADDR1;
                sbit_q <= 4'd0;
                sack_q <= 1'b0;
            end else if (scl_rise && sbit_q < 4'd8) begin
                sshift_q <= {sshift_q[6:0], sda_f_q};
                sbit_q <= sbit_q + 4'd1;
            end else if (scl_fall && sbit_q == 4'd9) begin
                sack_q <= 1'b0;
                sbit_q <= 4'd0;
            end else if (scl_fall && sbit_q == 4'd8) begin
                sbit_q <= 4'd9;
                sack_q <= 1'b0;
                sp_q <= SP_SKIP;
                case (sp_q)
                    SP_ADDR1: begin
                        if (sshift_q == 8'h00 && seq_q[`IMC_SEQ_GCALL]) begin
                            sack_q <= 1'b1;
                            sp_q <= SP_DATA;
                            event_q <= 1'b1;
                        end else if (is_ten && sshift_q == {5'b11110, addr_hi, 1'b0}) begin
                            sack_q <= 1'b1;
                            sp_q <= SP_ADDR2;
                        end else if (!is_ten && sshift_q[7:1] == baud_q[7:1]) begin
                            sack_q <= 1'b1;
                            sp_q <= SP_DATA;
                        end
                    end
                    SP_ADDR2: begin
                        if (sshift_q == baud_q) begin
                            sack_q <= 1'b1;
                            sp_q <= SP_DATA;
                        end
                    end
                    SP_DATA: begin
                        sack_q <= 1'b1;
                        sp_q <= SP_DATA;
                        event_q <= 1'b1;
                        if (bf_q) begin
                            ctl_q[`IMC_CTL_OVERFLOW] <= 1'b1;
                        end else begin
                            buf_q <= sshift_q;
                            bf_q <= 1'b1;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (is_slave && sp_events && (bus_start || bus_stop))
                event_q <= 1'b1;

            // pins are open drain: value held low, only the enables move
            if (is_master) begin
                SCL_OE_OUT <= eng_scl_oe;
                SDA_OE_OUT <= eng_sda_oe;
            end else if (is_fw) begin
                SCL_OE_OUT <= !aux_q[`IMC_AUX_FW_SCL];
                SDA_OE_OUT <= !aux_q[`IMC_AUX_FW_SDA];
            end else if (is_slave) begin
                SCL_OE_OUT <= !ctl_q[`IMC_CTL_CLK_RELEASE];
                SDA_OE_OUT <= sack_q;
            end else begin
                SCL_OE_OUT <= 1'b0;
                SDA_OE_OUT <= 1'b0;
            end
            PORT_EVENT_OUT <= event_q;
        end
    end
endmodule // imc_top

// File: tb/imc_checker_properties.sv
`timescale 1ns/10ps
module imc_checker (
    input wire CLK_SYS_IN,
    input wire SYS_RST_IN,
    input wire APB_PSEL_IN,
    input wire APB_PENABLE_IN,
    input wire APB_PWRITE_IN,
    input wire [7:0] APB_PADDR_IN,
    input wire [31:0] APB_PWDATA_IN,
    input wire [31:0] APB_PRDATA_OUT,
    input wire APB_PREADY_OUT,
    input wire APB_PSLVERR_OUT,
    input wire SCL_OUT,
    input wire SCL_OE_OUT,
    input wire SDA_OUT,
    input wire SDA_OE_OUT,
    input wire PORT_EVENT_OUT
);
    default clocking cb @(posedge CLK_SYS_IN);
    endclocking
    default disable iff (SYS_RST_IN);
    logic [7:0] ctl_q, baud_q, aux_q, per_q;
    logic [3:0] calm_q;
    logic oe_q;
    int q4;
    wire wr = APB_PREADY_OUT && APB_PSEL_IN && APB_PWRITE_IN && !APB_PSLVERR_OUT;
    wire bad = APB_PADDR_IN > 8'h14 || APB_PADDR_IN[1:0] != 2'b00;
    wire mst = ctl_q[5] && ctl_q[3:0] == 4'h8;
    wire fall = SCL_OE_OUT && !oe_q;
    assign q4 = 4 * (baud_q + 1);
    // shadow copies of the written config; calm_q lets the one-cycle pin lag settle
    always @(posedge CLK_SYS_IN) begin
        if (SYS_RST_IN) begin
            ctl_q <= 8'h00;
            baud_q <= 8'h00;
            aux_q <= 8'h03;
            calm_q <= 4'h0;
            per_q <= 8'hFF;
            oe_q <= 1'b0;
        end else begin
            oe_q <= SCL_OE_OUT;
            per_q <= fall ? 8'h00 : per_q + {7'h00, per_q != 8'hFF};
            calm_q <= wr ? 4'h0 : calm_q + {3'h0, calm_q != 4'hF};
            if (wr && APB_PADDR_IN == 8'h00) ctl_q <= APB_PWDATA_IN[7:0];
            if (wr && APB_PADDR_IN == 8'h08) baud_q <= APB_PWDATA_IN[7:0];
            if (wr && APB_PADDR_IN == 8'h14) aux_q <= APB_PWDATA_IN[7:0];
        end
    end
    property p_apb_wait;
        $rose(APB_PSEL_IN && APB_PENABLE_IN) |=> APB_PREADY_OUT;
    endproperty
    a_apb_wait: assert property (p_apb_wait) else $error("pready late");
    property p_apb_pulse;
        APB_PREADY_OUT |=> !APB_PREADY_OUT;
    endproperty
    a_apb_pulse: assert property (p_apb_pulse) else $error("pready held");
    property p_slverr;
        APB_PREADY_OUT |-> APB_PSLVERR_OUT == bad;
    endproperty
    a_slverr: assert property (p_slverr) else $error("pslverr wrong");
    property p_rd_zero;
        APB_PREADY_OUT && !APB_PWRITE_IN |-> APB_PRDATA_OUT[31:8] == 24'h00_0000
            && (!APB_PSLVERR_OUT || APB_PRDATA_OUT[7:0] == 8'h00);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("read data not zero");
    property p_open_drain;
        !SCL_OUT && !SDA_OUT;
    endproperty
    a_open_drain: assert property (p_open_drain) else $error("pin value high");
    property p_reserved;
        calm_q > 5 && !(ctl_q[3:0] inside {4'h6, 4'h7, 4'h8, 4'hB, 4'hE, 4'hF})
            |-> !SCL_OE_OUT && !SDA_OE_OUT;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved mode drives");
    property p_fw;
        calm_q > 5 && ctl_q[5] && ctl_q[3:0] == 4'hB
            |-> SCL_OE_OUT == !aux_q[1] && SDA_OE_OUT == !aux_q[0];
    endproperty
    a_fw: assert property (p_fw) else $error("firmware lines wrong");
    // only falls inside one op are timed; gaps between ops include bus traffic
    property p_period;
        mst && fall && per_q <= q4 |-> per_q == q4 - 1;
    endproperty
    a_period: assert property (p_period) else $error("scl period wrong");
    property p_start_ev;
        wr && APB_PADDR_IN == 8'h04 && APB_PWDATA_IN[0] && mst && !PORT_EVENT_OUT
            |-> ##[1:200] PORT_EVENT_OUT;
    endproperty
    a_start_ev: assert property (p_start_ev) else $error("start never done");
endmodule // imc_checker
bind imc_top imc_checker u_checker (.CLK_SYS_IN, .SYS_RST_IN, .APB_PSEL_IN, .APB_PENABLE_IN,
    .APB_PWRITE_IN, .APB_PADDR_IN, .APB_PWDATA_IN, .APB_PRDATA_OUT, .APB_PREADY_OUT,
    .APB_PSLVERR_OUT, .SCL_OUT, .SCL_OE_OUT, .SDA_OUT, .SDA_OE_OUT, .PORT_EVENT_OUT);

// File: tb/imc_bus_partner.sv
`timescale 1ns/10ps
module imc_bus_partner (
    input wire scl_oe_in,
    input wire sda_oe_in,
    input wire rd_in,
    input wire ack_in,
    input wire pull_in,
    input wire [7:0] tx_in,
    output wire scl_out,
    output wire sda_out,
    output logic [7:0] rx_out,
    output logic ack_seen_out
);
    logic [3:0] slot = 4'h9;
    wire drv = rd_in ? (slot < 8 && !tx_in[3'd7 - slot[2:0]]) : (slot == 8 && ack_in);
    // pull-ups on both lines; this peer never stretches the clock
    assign scl_out = scl_oe_in !== 1'b1;
    assign sda_out = !(sda_oe_in === 1'b1 || drv || pull_in);
    always @(negedge sda_out) if (scl_out) slot = 4'h9;
    always @(posedge scl_out) begin
        if (slot < 8) rx_out = {rx_out[6:0], sda_out};
        if (slot == 8) ack_seen_out = sda_out;
    end
    always @(negedge scl_out) slot = (slot >= 8) ? 4'h0 : slot + 4'h1;
endmodule // imc_bus_partner

// File: tb/tb_i2c_mode_and_master_control.sv
`timescale 1ns/10ps
module tb_i2c_mode_and_master_control;
    logic clk = 0;
    logic rst = 1;
    logic psel = 0;
    logic stop_sequence_enable = 0;
    logic pwr = 0;
    logic rd = 0;
    logic ack = 0;
    logic pull = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] tx = 8'h00;
    logic [31:0] prdata, rdat;
    logic [7:0] rx, d;
    logic pready, pslverr, perr, scl_oe, sda_oe, scl, sda, ev, ackd;
    int error_cnt = 0;
    int n_checks = 0;
    imc_top dut (.CLK_SYS_IN(clk), .SYS_RST_IN(rst), .CE_IN(1'b1), .APB_PSEL_IN(psel),
        .APB_PENABLE_IN(stop_sequence_enable), .APB_PWRITE_IN(pwr), .APB_PADDR_IN(paddr), .APB_PWDATA_IN(pwdata),
        .APB_PRDATA_OUT(prdata), .APB_PREADY_OUT(pready), .APB_PSLVERR_OUT(pslverr),
        .SCL_IN(scl), .SDA_IN(sda), .SCL_OUT(), .SCL_OE_OUT(scl_oe), .SDA_OUT(),
        .SDA_OE_OUT(sda_oe), .PORT_EVENT_OUT(ev));
    imc_bus_partner peer (.scl_oe_in(scl_oe), .sda_oe_in(sda_oe), .rd_in(rd), .ack_in(ack),
        .pull_in(pull), .tx_in(tx), .scl_out(scl), .sda_out(sda), .rx_out(rx),
        .ack_seen_out(ackd));
    initial forever #5 clk = ~clk;
    task automatic complete_run;
        if (error_cnt == 0 && n_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
        int i;
        i = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= dat;
        @(posedge clk);
        stop_sequence_enable <= 1'b1;
        do begin
            @(posedge clk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        rdat = prdata;
        perr = pslverr;
        psel <= 1'b0;
        stop_sequence_enable <= 1'b0;
        if (i >= 20) begin
            chk(0, 1);
            complete_run();
        end
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(rdat, e);
    endtask
    // waits for an op to finish, then clears the event flag for the next one
    task automatic wev;
        int i;
        for (i = 0; i < 600 && ev !== 1'b1; i++) @(posedge clk);
        if (i >= 600) begin
            chk(0, 1);
            complete_run();
        end
        apb(1'b1, 8'h10, 32'h0000_0002);
    endtask
    initial begin
        int k;
        void'($urandom(92097));
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        rchk(8'h00, 32'h0000_0000);
        rchk(8'h04, 32'h0000_0000);
        rchk(8'h14, 32'h0000_0033);
        rchk(8'h18, 32'h0000_0000);
        chk(perr, 1);
        d = 8'h03 + $urandom % 4;
        apb(1'b1, 8'h08, {24'h00_0000, d});
        for (k = 0; k < 16; k++) begin
            apb(1'b1, 8'h00, 32'h0000_0030 | k);
            rchk(8'h00, 32'h0000_0030 | k);
            if (k == 11) begin
                d = $urandom % 4;
                apb(1'b1, 8'h14, {24'h00_0000, d});
                repeat (8) @(posedge clk);
                chk({scl_oe, sda_oe}, {30'h0, ~d[1:0]});
            end
            repeat (8) @(posedge clk);
        end
        apb(1'b1, 8'h00, 32'h0000_0028);
        apb(1'b1, 8'h04, 32'h0000_0001);
        wev();
        rchk(8'h04, 32'h0000_0000);
        for (k = 0; k < 2; k++) begin
            ack <= (k == 0);
            d = $urandom;
            apb(1'b1, 8'h0C, {24'h00_0000, d});
            if (k == 0) apb(1'b1, 8'h0C, 32'h0000_00FF);
            wev();
            chk(rx, d);
            rchk(8'h04, k ? 32'h0000_0040 : 32'h0000_0000);
            if (k == 0) rchk(8'h00, 32'h0000_00A8);
            apb(1'b1, 8'h00, 32'h0000_0028);
        end
        tx <= $urandom;
        rd <= 1'b1;
        apb(1'b1, 8'h04, 32'h0000_0008);
        wev();
        rchk(8'h0C, {24'h00_0000, tx});
        rchk(8'h00, 32'h0000_0028);
        apb(1'b1, 8'h04, 32'h0000_0030);
        wev();
        chk(ackd, 1);
        rd <= 1'b0;
        apb(1'b1, 8'h04, 32'h0000_0024);
        wev();
        rchk(8'h04, 32'h0000_0060);
        repeat (8) @(posedge clk);
        chk({scl_oe, sda_oe}, 0);
        // a start then a stop on the idle bus: only the 1110 slave flags them
        for (k = 0; k < 2; k++) begin
            apb(1'b1, 8'h00, k ? 32'h0000_003E : 32'h0000_0036);
            pull <= 1'b1;
            repeat (8) @(posedge clk);
            pull <= 1'b0;
            repeat (8) @(posedge clk);
            chk(ev, k);
            apb(1'b1, 8'h10, 32'h0000_0002);
        end
        complete_run();
    end
endmodule // tb_i2c_mode_and_master_control
